// >>> lapm_cfg.svh
`ifndef LAPM_CFG_SVH
`define LAPM_CFG_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define LAPM_IDX_MODE 10'h00B
`define LAPM_IDX_DIRECT 10'h011
`define LAPM_IDX_PROGRAM_PAGE_SELECT 10'h015
`define LAPM_IDX_DBGPAGE 10'h016
`define LAPM_IDX_CTRL 10'h017

// ----------------------------------------
// field positions
// ----------------------------------------
`define LAPM_MODE_BIT 7
`define LAPM_CTRL_DBGPAGE_EN_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define LAPM_RST_DIRECT 8'h00
`define LAPM_RST_PROGRAM_PAGE_SELECT 4'hE
`define LAPM_RST_DBGPAGE 4'h0

// ----------------------------------------
// fixed page numbers and overlay windows
// ----------------------------------------
`define LAPM_PAGE_FIX_LOW 8'h0C
`define LAPM_PAGE_FIX_MID 8'h0D
`define LAPM_PAGE_FIX_TOP 8'h0F
`define LAPM_OVL_TOP_HI 8'hFF
`define LAPM_OVL_WIN_HI 8'hBF
`define LAPM_OVL_WIN_PAGE 8'h0F

`endif

// >>> lapm_pkg.sv
package lapm_pkg;

    typedef logic [15:0] lapm_laddr_t;
    typedef logic [17:0] lapm_gaddr_t;
    typedef logic [3:0] lapm_page_t;
    typedef logic [7:0] lapm_byte_t;

endpackage

// >>> lapm_map_if.sv
`timescale 1ns/1ps

interface lapm_map_if;
    lapm_pkg::lapm_laddr_t local_addr;
    lapm_pkg::lapm_page_t page_idx;
    lapm_pkg::lapm_page_t program_page;
    logic debug_view;
    lapm_pkg::lapm_gaddr_t global_addr;
    logic ovl_hit;
    logic res_sel;

    modport master (
        output local_addr,
        output page_idx,
        output program_page,
        output debug_view,
        input global_addr,
        input ovl_hit,
        input res_sel
    );

    modport xlate (
        input local_addr,
        input page_idx,
        input program_page,
        input debug_view,
        output global_addr,
        output ovl_hit,
        output res_sel
    );
endinterface

// >>> lapm_xlate.sv
`timescale 1ns/1ps
`include "lapm_cfg.svh"

module lapm_xlate (
    lapm_map_if.xlate m
);

    localparam logic [7:0] page_low = `LAPM_PAGE_FIX_LOW;
    localparam logic [7:0] page_mid = `LAPM_PAGE_FIX_MID;
    localparam logic [7:0] page_top = `LAPM_PAGE_FIX_TOP;
    localparam logic [7:0] ovl_top = `LAPM_OVL_TOP_HI;
    localparam logic [7:0] ovl_win = `LAPM_OVL_WIN_HI;
    localparam logic [7:0] ovl_page = `LAPM_OVL_WIN_PAGE;

    logic in_top;
    logic in_win;

    // ----------------------------------------
    // local to global expansion
    // ----------------------------------------
    always_comb begin
        case (m.local_addr[15:14])
            2'b00: m.global_addr = {page_low[3:0], m.local_addr[13:0]};
            2'b01: m.global_addr = {page_mid[3:0], m.local_addr[13:0]};
            2'b10: m.global_addr = {m.page_idx, m.local_addr[13:0]};
            2'b11: m.global_addr = {page_top[3:0], m.local_addr[13:0]};
            default: m.global_addr = {page_top[3:0], m.local_addr[13:0]};
        endcase
    end

    // ----------------------------------------
    // debug overlay
    // ----------------------------------------
    always_comb begin
        in_top = (m.local_addr[15:8] == ovl_top);
        in_win = (m.local_addr[15:8] == ovl_win) && (m.program_page == ovl_page[3:0]);
        m.ovl_hit = m.debug_view && (in_top || in_win);
        m.res_sel = !m.ovl_hit;
    end

endmodule // lapm_xlate

// >>> lapm_mode.sv
`timescale 1ns/1ps

module lapm_mode (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic mode_select_pin,
    input wire logic debug_active,
    output logic normal_single_chip,
    output logic debug_req
);

    logic captured;

    // ----------------------------------------
    // mode strap capture at reset release
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            captured <= 1'b0;
            normal_single_chip <= 1'b1;
        end else if (!captured) begin
            captured <= 1'b1;
            normal_single_chip <= mode_select_pin;
        end
    end

    // ----------------------------------------
    // special mode holds the core in debug
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            debug_req <= 1'b0;
        end else begin
            debug_req <= captured && !normal_single_chip && !debug_active;
        end
    end

endmodule // lapm_mode

// >>> lapm_top.sv
`timescale 1ns/1ps
`include "lapm_cfg.svh"

// Overview of operation
// - direct page readable always; writable freely in special, once in normal mode
// - direct-mode CPU accesses take direct page bits as local address bits 15:8
// - direct page placement applies to both global and local mapping
// - four page index bits select the 16KB block seen at 0x8000-0xBFFF
// - CPU call/return page updates take effect at the next clock edge
// - local 0x0000-0x3FFF maps to fixed page 0x0C
// - local 0x4000-0x7FFF maps to fixed page 0x0D
// - local 0xC000-0xFFFF maps to fixed page 0x0F
// - program page select resets to 0x0E for linear flash
// - debug tables hidden except in debug mode or debug read/write cycles
// - active debug shows debug tables at local 0xFF00-0xFFFF
// - resources sharing debug overlay addresses are deselected while overlay shows
// - in debug with page 0x0F, debug tables also appear at 0xBF00-0xBFFF
// - debug page select has four bits and the same expansion scheme
// - debug page select used only when enabled, for firmware or hardware commands
// - both page registers readable and writable by the debug module
// - local 0xC000-0xFFFF stays unpaged
// - normal single-chip mode has no external bus
// - special mode keeps the core in active debug awaiting commands
// - mode pin captured at reset release selects normal or special mode
module lapm_top (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] CPU_ADDR,
    input wire logic CPU_DIRECT,
    input wire logic CPU_PAGE_WE,
    input wire logic [7:0] CPU_PAGE_WDATA,
    input wire logic CPU_FW_CMD,
    input wire logic [15:0] DBG_ADDR,
    input wire logic DBG_HW_CMD,
    input wire logic DEBUG_READ_CYCLE,
    input wire logic DEBUG_WRITE_CYCLE,
    input wire logic BACKGROUND_DEBUG_ACTIVE,
    input wire logic MODE_SELECT_PIN,
    output logic [17:0] CPU_GADDR,
    output logic CPU_OVL_SEL,
    output logic CPU_RES_SEL,
    output logic [17:0] DBG_GADDR,
    output logic DBG_OVL_SEL,
    output logic DBG_RES_SEL,
    output logic NORMAL_SINGLE_CHIP,
    output logic BACKGROUND_DEBUG_REQ,
    output logic EXT_BUS_EN
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    localparam logic [9:0] idx_mode = `LAPM_IDX_MODE;
    localparam logic [9:0] idx_direct = `LAPM_IDX_DIRECT;
    localparam logic [9:0] idx_program_page_select = `LAPM_IDX_PROGRAM_PAGE_SELECT;
    localparam logic [9:0] idx_dbgpage = `LAPM_IDX_DBGPAGE;
    localparam logic [9:0] idx_ctrl = `LAPM_IDX_CTRL;

    lapm_pkg::lapm_byte_t direct_page_base;
    logic direct_written;
    lapm_pkg::lapm_page_t program_page_select;
    lapm_pkg::lapm_page_t debug_page_select;
    logic debug_page_enable;

    logic normal_single_chip;
    logic debug_req;

    logic [9:0] reg_idx;
    logic addr_ok;
    logic apb_setup;
    logic apb_write;
    logic [31:0] next_prdata;
    logic next_pslverr;

    logic debug_view;
    lapm_pkg::lapm_laddr_t cpu_local;
    lapm_pkg::lapm_page_t cpu_page;
    lapm_pkg::lapm_page_t dbg_page;

    lapm_map_if cpu_map ();
    lapm_map_if dbg_map ();

    // ----------------------------------------
    // operating mode
    // ----------------------------------------
    lapm_mode u_mode (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .mode_select_pin(MODE_SELECT_PIN),
        .debug_active(BACKGROUND_DEBUG_ACTIVE),
        .normal_single_chip(normal_single_chip),
        .debug_req(debug_req)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    always_comb begin
        reg_idx = PADDR[11:2];
        addr_ok = (PADDR[1:0] == 2'b00) &&
                  ((reg_idx == idx_mode) || (reg_idx == idx_direct) ||
                   (reg_idx == idx_program_page_select) || (reg_idx == idx_dbgpage) ||
                   (reg_idx == idx_ctrl));
        apb_setup = PSEL && !PENABLE;
        apb_write = PSEL && PENABLE && PREADY && PWRITE && addr_ok;
    end

    // ----------------------------------------
    // apb read data
    // ----------------------------------------
    always_comb begin
        next_prdata = 32'h00000000;
        next_pslverr = !addr_ok;
        if (reg_idx == idx_mode) begin
            next_prdata[`LAPM_MODE_BIT] = normal_single_chip;
        end else if (reg_idx == idx_direct) begin
            next_prdata[7:0] = direct_page_base;
        end else if (reg_idx == idx_program_page_select) begin
            next_prdata[3:0] = program_page_select;
        end else if (reg_idx == idx_dbgpage) begin
            next_prdata[3:0] = debug_page_select;
        end else if (reg_idx == idx_ctrl) begin
            next_prdata[`LAPM_CTRL_DBGPAGE_EN_BIT] = debug_page_enable;
        end
    end

    // ----------------------------------------
    // apb response, one access cycle
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= apb_setup;
            if (apb_setup) begin
                PSLVERR <= next_pslverr;
                PRDATA <= PWRITE ? 32'h00000000 : next_prdata;
            end else begin
                PSLVERR <= 1'b0;
                PRDATA <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // direct page register
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            direct_page_base <= `LAPM_RST_DIRECT;
            direct_written <= 1'b0;
        end else if (apb_write && (reg_idx == idx_direct)) begin
            if (!normal_single_chip || !direct_written) begin
                direct_page_base <= PWDATA[7:0];
                direct_written <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // program page select
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            program_page_select <= `LAPM_RST_PROGRAM_PAGE_SELECT;
        end else if (CPU_PAGE_WE) begin
            program_page_select <= CPU_PAGE_WDATA[3:0];
        end else if (apb_write && (reg_idx == idx_program_page_select)) begin
            program_page_select <= PWDATA[3:0];
        end
    end

    // ----------------------------------------
    // debug page select and its enable
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            debug_page_select <= `LAPM_RST_DBGPAGE;
        end else if (apb_write && (reg_idx == idx_dbgpage)) begin
            debug_page_select <= PWDATA[3:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            debug_page_enable <= 1'b0;
        end else if (apb_write && (reg_idx == idx_ctrl)) begin
            debug_page_enable <= PWDATA[`LAPM_CTRL_DBGPAGE_EN_BIT];
        end
    end

    // ----------------------------------------
    // master address preparation
    // ----------------------------------------
    always_comb begin
        debug_view = BACKGROUND_DEBUG_ACTIVE || DEBUG_READ_CYCLE || DEBUG_WRITE_CYCLE;
        cpu_local = CPU_DIRECT ? {direct_page_base, CPU_ADDR[7:0]} : CPU_ADDR;
        cpu_page = (debug_page_enable && CPU_FW_CMD) ? debug_page_select : program_page_select;
        dbg_page = (debug_page_enable && DBG_HW_CMD) ? debug_page_select : program_page_select;
    end

    assign cpu_map.local_addr = cpu_local;
    assign cpu_map.page_idx = cpu_page;
    assign cpu_map.program_page = program_page_select;
    assign cpu_map.debug_view = debug_view;

    assign dbg_map.local_addr = DBG_ADDR;
    assign dbg_map.page_idx = dbg_page;
    assign dbg_map.program_page = program_page_select;
    assign dbg_map.debug_view = debug_view;

    // ----------------------------------------
    // expansion units
    // ----------------------------------------
    lapm_xlate u_cpu_xlate (
        .m(cpu_map.xlate)
    );

    lapm_xlate u_dbg_xlate (
        .m(dbg_map.xlate)
    );

    // ----------------------------------------
    // registered map outputs
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CPU_GADDR <= 18'h00000;
            CPU_OVL_SEL <= 1'b0;
            CPU_RES_SEL <= 1'b0;
        end else begin
            CPU_GADDR <= cpu_map.global_addr;
            CPU_OVL_SEL <= cpu_map.ovl_hit;
            CPU_RES_SEL <= cpu_map.res_sel;
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DBG_GADDR <= 18'h00000;
            DBG_OVL_SEL <= 1'b0;
            DBG_RES_SEL <= 1'b0;
        end else begin
            DBG_GADDR <= dbg_map.global_addr;
            DBG_OVL_SEL <= dbg_map.ovl_hit;
            DBG_RES_SEL <= dbg_map.res_sel;
        end
    end

    // ----------------------------------------
    // mode outputs
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            NORMAL_SINGLE_CHIP <= 1'b1;
            BACKGROUND_DEBUG_REQ <= 1'b0;
            EXT_BUS_EN <= 1'b0;
        end else begin
            NORMAL_SINGLE_CHIP <= normal_single_chip;
            BACKGROUND_DEBUG_REQ <= debug_req;
            EXT_BUS_EN <= 1'b0;
        end
    end

endmodule // lapm_top

// >>> lapm_props.sv
`timescale 1ns/1ps
// --------
// port checker
// --------
module lapm_props (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic [15:0] CPU_ADDR,
    input wire logic CPU_DIRECT,
    input wire logic DEBUG_READ_CYCLE,
    input wire logic DEBUG_WRITE_CYCLE,
    input wire logic BACKGROUND_DEBUG_ACTIVE,
    input wire logic [17:0] CPU_GADDR,
    input wire logic CPU_OVL_SEL,
    input wire logic CPU_RES_SEL,
    input wire logic DBG_OVL_SEL,
    input wire logic NORMAL_SINGLE_CHIP,
    input wire logic BACKGROUND_DEBUG_REQ,
    input wire logic EXT_BUS_EN
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    property p_low; !CPU_DIRECT && CPU_ADDR[15:14] == 2'b00 |=> CPU_GADDR[17:14] == 4'hC; endproperty
    a_low: assert property (p_low) else $error("low page wrong");
    property p_mid; !CPU_DIRECT && CPU_ADDR[15:14] == 2'b01 |=> CPU_GADDR[17:14] == 4'hD; endproperty
    a_mid: assert property (p_mid) else $error("mid page wrong");
    property p_top; !CPU_DIRECT && CPU_ADDR[15:14] == 2'b11 |=> CPU_GADDR[17:14] == 4'hF; endproperty
    a_top: assert property (p_top) else $error("top page wrong");
    property p_off; !CPU_DIRECT |=> CPU_GADDR[13:0] == $past(CPU_ADDR[13:0]); endproperty
    a_off: assert property (p_off) else $error("offset bits wrong");
    property p_dir; CPU_DIRECT |=> CPU_GADDR[7:0] == $past(CPU_ADDR[7:0]); endproperty
    a_dir: assert property (p_dir) else $error("direct low byte wrong");
    property p_hide; !(BACKGROUND_DEBUG_ACTIVE || DEBUG_READ_CYCLE || DEBUG_WRITE_CYCLE) |=> !CPU_OVL_SEL && !DBG_OVL_SEL; endproperty
    a_hide: assert property (p_hide) else $error("overlay outside debug");
    property p_show; BACKGROUND_DEBUG_ACTIVE && !CPU_DIRECT && CPU_ADDR[15:8] == 8'hFF |=> CPU_OVL_SEL && !CPU_RES_SEL; endproperty
    a_show: assert property (p_show) else $error("overlay not shown");
    property p_ext; !EXT_BUS_EN; endproperty
    a_ext: assert property (p_ext) else $error("external bus enabled");
    property p_req; BACKGROUND_DEBUG_REQ |-> !NORMAL_SINGLE_CHIP; endproperty
    a_req: assert property (p_req) else $error("debug request in normal mode");
endmodule // lapm_props

bind lapm_top lapm_props lapm_props_i (.CORE_CLK, .ARST_N, .PSEL, .PENABLE, .PREADY, .CPU_ADDR, .CPU_DIRECT,
    .DEBUG_READ_CYCLE, .DEBUG_WRITE_CYCLE, .BACKGROUND_DEBUG_ACTIVE, .CPU_GADDR, .CPU_OVL_SEL, .CPU_RES_SEL,
    .DBG_OVL_SEL, .NORMAL_SINGLE_CHIP, .BACKGROUND_DEBUG_REQ, .EXT_BUS_EN);

// >>> lapm_master_model.sv
`timescale 1ns/1ps
// --------
// cpu and debug master stand-in
// --------
module lapm_master_model (
    input wire logic clk,
    output logic [15:0] cpu_addr,
    output logic cpu_direct,
    output logic cpu_page_we,
    output logic [7:0] cpu_page_wdata,
    output logic [15:0] dbg_addr,
    output logic [4:0] ctl
);
    // idle levels before the first request
    initial begin
        cpu_addr = 16'h0000;
        cpu_direct = 1'b0;
        cpu_page_we = 1'b0;
        cpu_page_wdata = 8'h00;
        dbg_addr = 16'h0000;
        ctl = 5'h00;
    end
    task automatic access(input logic [15:0] a, input logic d);
        @(posedge clk);
        cpu_addr <= a;
        dbg_addr <= a;
        cpu_direct <= d;
        @(posedge clk);
        #1;
    endtask
    // one-cycle page switch of a subroutine call or return
    task automatic page_call(input logic [7:0] pg);
        @(posedge clk);
        cpu_page_we <= 1'b1;
        cpu_page_wdata <= pg;
        @(posedge clk);
        cpu_page_we <= 1'b0;
        cpu_page_wdata <= ~pg;
    endtask
    // fw, hw, active, read cycle, write cycle
    task automatic set_ctl(input logic [4:0] v);
        @(posedge clk);
        ctl <= v;
    endtask
endmodule // lapm_master_model

// >>> lapm_bench.sv
`timescale 1ns/1ps
`include "lapm_cfg.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module lapm_bench;
    logic core_clk = 1'b0;
    logic arst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic mode_pin;
    logic [31:0] prdata;
    logic pready, pslverr, cpu_ovl, cpu_res, dbg_ovl, dbg_res, nsc, req, ext, cpu_direct, page_we;
    logic [17:0] cpu_gaddr, dbg_gaddr;
    logic [15:0] cpu_addr, dbg_addr;
    logic [7:0] page_wdata;
    logic [4:0] ctl;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    lapm_master_model lapm_master_model_i (.clk(core_clk), .cpu_addr(cpu_addr), .cpu_direct(cpu_direct),
        .cpu_page_we(page_we), .cpu_page_wdata(page_wdata), .dbg_addr(dbg_addr), .ctl(ctl));
    lapm_top lapm_top_i (.CORE_CLK(core_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CPU_ADDR(cpu_addr), .CPU_DIRECT(cpu_direct), .CPU_PAGE_WE(page_we), .CPU_PAGE_WDATA(page_wdata),
        .CPU_FW_CMD(ctl[4]), .DBG_ADDR(dbg_addr), .DBG_HW_CMD(ctl[3]), .DEBUG_READ_CYCLE(ctl[1]),
        .DEBUG_WRITE_CYCLE(ctl[0]), .BACKGROUND_DEBUG_ACTIVE(ctl[2]), .MODE_SELECT_PIN(mode_pin),
        .CPU_GADDR(cpu_gaddr), .CPU_OVL_SEL(cpu_ovl), .CPU_RES_SEL(cpu_res), .DBG_GADDR(dbg_gaddr),
        .DBG_OVL_SEL(dbg_ovl), .DBG_RES_SEL(dbg_res), .NORMAL_SINGLE_CHIP(nsc),
        .BACKGROUND_DEBUG_REQ(req), .EXT_BUS_EN(ext));
    initial forever #25 core_clk = ~core_clk;
    // --------
    // bus and map tasks
    // --------
    task automatic results;
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            results();
        end
    end
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
        `CHK(e, 1'b0)
    endtask
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        `CHK(r, exp)
        `CHK(e, err)
    endtask
    task automatic map(input logic [15:0] a, input logic d, input logic [17:0] cg, input logic [17:0] dg,
        input logic ov);
        lapm_master_model_i.access(a, d);
        `CHK(cpu_gaddr, cg)
        `CHK(dbg_gaddr, dg)
        `CHK(cpu_ovl, ov)
        `CHK(cpu_res, ~ov)
        `CHK(dbg_ovl, ov & ~d)
        `CHK(dbg_res, ~(ov & ~d))
    endtask
    // --------
    // main sequence
    // --------
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        mode_pin = 1'b1;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`LAPM_IDX_PROGRAM_PAGE_SELECT, 32'h0000000E, 1'b0);
        rd(`LAPM_IDX_DIRECT, 32'h0, 1'b0);
        rd(`LAPM_IDX_DBGPAGE, 32'h0, 1'b0);
        rd(`LAPM_IDX_MODE, 32'h80, 1'b0);
        rd(10'h3FF, 32'h0, 1'b1);
        `CHK(nsc, 1'b1)
        `CHK(ext, 1'b0)
        map(16'h1234, 1'b0, 18'h31234, 18'h31234, 1'b0);
        map(16'h4567, 1'b0, 18'h34567, 18'h34567, 1'b0);
        map(16'h8123, 1'b0, 18'h38123, 18'h38123, 1'b0);
        map(16'hC00F, 1'b0, 18'h3C00F, 18'h3C00F, 1'b0);
        wr(`LAPM_IDX_DIRECT, 32'h80);
        wr(`LAPM_IDX_DIRECT, 32'h40);
        rd(`LAPM_IDX_DIRECT, 32'h80, 1'b0);
        wr(`LAPM_IDX_PROGRAM_PAGE_SELECT, 32'h5);
        map(16'h8123, 1'b0, 18'h14123, 18'h14123, 1'b0);
        map(16'hC00F, 1'b0, 18'h3C00F, 18'h3C00F, 1'b0);
        lapm_master_model_i.page_call(8'h07);
        rd(`LAPM_IDX_PROGRAM_PAGE_SELECT, 32'h7, 1'b0);
        map(16'hBFFF, 1'b0, 18'h1FFFF, 18'h1FFFF, 1'b0);
        map(16'h0023, 1'b1, 18'h1C023, 18'h30023, 1'b0);
        wr(`LAPM_IDX_DBGPAGE, 32'h3);
        wr(`LAPM_IDX_CTRL, 32'h1);
        lapm_master_model_i.set_ctl(5'b10000);
        map(16'h8001, 1'b0, 18'h0C001, 18'h1C001, 1'b0);
        lapm_master_model_i.set_ctl(5'b01000);
        map(16'h8001, 1'b0, 18'h1C001, 18'h0C001, 1'b0);
        wr(`LAPM_IDX_CTRL, 32'h0);
        map(16'h8001, 1'b0, 18'h1C001, 18'h1C001, 1'b0);
        lapm_master_model_i.set_ctl(5'b00100);
        map(16'hFF10, 1'b0, 18'h3FF10, 18'h3FF10, 1'b1);
        map(16'hBF10, 1'b0, 18'h1FF10, 18'h1FF10, 1'b0);
        wr(`LAPM_IDX_PROGRAM_PAGE_SELECT, 32'hF);
        map(16'hBF10, 1'b0, 18'h3FF10, 18'h3FF10, 1'b1);
        lapm_master_model_i.set_ctl(5'b00010);
        map(16'hFF10, 1'b0, 18'h3FF10, 18'h3FF10, 1'b1);
        lapm_master_model_i.set_ctl(5'b00001);
        map(16'hFF10, 1'b0, 18'h3FF10, 18'h3FF10, 1'b1);
        lapm_master_model_i.set_ctl(5'b00000);
        map(16'hFF10, 1'b0, 18'h3FF10, 18'h3FF10, 1'b0);
        @(posedge core_clk);
        arst_n <= 1'b0;
        mode_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(nsc, 1'b0)
        `CHK(req, 1'b1)
        rd(`LAPM_IDX_MODE, 32'h0, 1'b0);
        wr(`LAPM_IDX_DIRECT, 32'h80);
        wr(`LAPM_IDX_DIRECT, 32'h40);
        rd(`LAPM_IDX_DIRECT, 32'h40, 1'b0);
        lapm_master_model_i.set_ctl(5'b00100);
        map(16'h0023, 1'b1, 18'h34023, 18'h30023, 1'b0);
        `CHK(req, 1'b0)
        results();
    end
endmodule // lapm_bench
